// [rtl/csup_act_if.sv]
`timescale 1ns/1ns
`default_nettype none

// Activity report of one pulse monitor channel
interface csup_act_if;
    logic pulse_edge;
    logic stale;

    modport mon (output pulse_edge, output stale);
    modport sup (input pulse_edge, input stale);
endinterface : csup_act_if

`default_nettype wire

// [rtl/csup_pkg.sv]
package csup_pkg;

    // System clock rate
    localparam longint CLK_HZ = 64'd10_000_000;
    localparam longint CYC_PER_MS = CLK_HZ / 64'd1000;

    // Hold after speed-pulse loss before the lid lock may release
    localparam longint HOLD_MIN = 64'd3;
    localparam int unsigned HOLD_CYC = 32'(HOLD_MIN * 64'd60 * CLK_HZ);

    // Pulse supervision timeouts in milliseconds
    localparam longint PULSE_TO_MS = 64'd100;
    localparam longint STILL_TO_MS = 64'd500;
    localparam longint IMB_TO_MS = 64'd50;
    localparam longint MAINS_TO_MS = 64'd100;
    localparam longint POWERUP_MS = 64'd1000;
    localparam int unsigned PULSE_TO_CYC = 32'(PULSE_TO_MS * CYC_PER_MS);
    localparam int unsigned STILL_TO_CYC = 32'(STILL_TO_MS * CYC_PER_MS);
    localparam int unsigned IMB_TO_CYC = 32'(IMB_TO_MS * CYC_PER_MS);
    localparam int unsigned MAINS_TO_CYC = 32'(MAINS_TO_MS * CYC_PER_MS);
    localparam int unsigned POWERUP_CYC = 32'(POWERUP_MS * CYC_PER_MS);

    // Indicator blink half period
    localparam longint BLINK_MS = 64'd250;
    localparam int unsigned BLINK_CYC = 32'(BLINK_MS * CYC_PER_MS);

    // Monitor channel positions
    localparam int CH_TOP = 0;
    localparam int CH_BOT = 1;
    localparam int CH_IMBX = 2;
    localparam int CH_IMBY = 3;
    localparam int CH_MAINS = 4;
    localparam int CH_TOP_STILL = 5;
    localparam int CH_BOT_STILL = 6;
    localparam int NUM_CH = 7;

    // Displayed error numbers (major.minor)
    localparam logic [7:0] ERR_PULSE_TOP = 8'h01;
    localparam logic [7:0] ERR_PULSE_BOTH = 8'h02;
    localparam logic [7:0] ERR_LID = 8'h04;
    localparam logic [7:0] ERR_LID_MINOR = 8'h01;
    localparam logic [7:0] ERR_MAINS = 8'h5a;
    localparam logic [7:0] ERR_IMB_X = 8'h5b;
    localparam logic [7:0] ERR_IMB_Y = 8'h5c;
    localparam logic [7:0] ERR_IMB_TEMP = 8'h5d;
    localparam logic [7:0] ERR_PULSE_BOT = 8'h60;
    localparam logic [7:0] ERR_TEMP_DEF = 8'h61;
    localparam logic [7:0] ERR_TEMP_OVER = 8'h62;
    localparam logic [7:0] ERR_SUM_SINGLE = 8'h64;
    localparam logic [7:0] ERR_SUM_LINKED = 8'h65;
    localparam logic [7:0] ERR_NONE = 8'h00;

    // Fault kinds; named faults without a number show major 0
    typedef enum logic [4:0] {
        CSUP_F_NONE,
        CSUP_F_PULSE_TOP,
        CSUP_F_PULSE_BOTH,
        CSUP_F_IMBALANCE,
        CSUP_F_LID_HOOK,
        CSUP_F_MAINS,
        CSUP_F_IMB_X,
        CSUP_F_IMB_Y,
        CSUP_F_IMB_TEMP,
        CSUP_F_PULSE_BOT,
        CSUP_F_TEMP_DEF,
        CSUP_F_TEMP_OVER,
        CSUP_F_SUM_SINGLE,
        CSUP_F_SUM_LINKED,
        CSUP_F_NO_ROTOR,
        CSUP_F_OVERSPEED,
        CSUP_F_CONV_INIT
    } csup_fault_t;

endpackage : csup_pkg

// [rtl/csup_pulse_mon.sv]
`timescale 1ns/1ns
`default_nettype none

module csup_pulse_mon #(
    parameter int unsigned TIMEOUT = 32'd1000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pulse input and count restart
    input wire logic sig,
    input wire logic restart,
    // Activity report
    csup_act_if.mon act
);

    logic sig_prev_reg;
    logic edge_reg;
    logic [31:0] cnt_reg;
    logic stale_reg;
    logic seen_edge;

    assign seen_edge = sig ^ sig_prev_reg;

    // Edge detect on the synchronous input
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sig_prev_reg <= 1'b0;
            edge_reg <= 1'b0;
        end else begin
            sig_prev_reg <= sig;
            edge_reg <= seen_edge;
        end
    end

    // Time since the last edge; saturates so stale stays up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 32'h0;
            stale_reg <= 1'b0;
        end else if (seen_edge || restart) begin
            cnt_reg <= 32'h0;
            stale_reg <= 1'b0;
        end else if (cnt_reg >= TIMEOUT - 32'd1) begin
            stale_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'd1;
        end
    end

    assign act.pulse_edge = edge_reg;
    assign act.stale = stale_reg;

endmodule : csup_pulse_mon

`default_nettype wire

// [rtl/csup_supervisor.sv]
`timescale 1ns/1ns
`default_nettype none

module csup_supervisor #(
    parameter int unsigned PULSE_TO = csup_pkg::PULSE_TO_CYC,
    parameter int unsigned STILL_TO = csup_pkg::STILL_TO_CYC,
    parameter int unsigned IMB_TO = csup_pkg::IMB_TO_CYC,
    parameter int unsigned MAINS_TO = csup_pkg::MAINS_TO_CYC,
    parameter int unsigned POWERUP = csup_pkg::POWERUP_CYC,
    parameter int unsigned HOLD = csup_pkg::HOLD_CYC,
    parameter int unsigned BLINK = csup_pkg::BLINK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pulse trains from sensors and mains
    input wire logic top_speed_sensor,
    input wire logic bottom_speed_sensor,
    input wire logic imbalance_x,
    input wire logic imbalance_y,
    input wire logic mains_sync,
    // Sensor and controller status levels
    input wire logic imbalance_detect,
    input wire logic imbalance_temp_defect,
    input wire logic board_temp_defect,
    input wire logic board_temp_over,
    input wire logic single_program_checksum_fault,
    input wire logic linked_program_checksum_fault,
    input wire logic converter_init_fault,
    input wire logic no_rotor_fault,
    // Program load check
    input wire logic program_load,
    input wire logic [15:0] program_speed,
    input wire logic [15:0] rotor_max_speed,
    // Run and lid state
    input wire logic run_cmd,
    input wire logic lid_closed,
    input wire logic hook_left_closed,
    input wire logic hook_right_closed,
    input wire logic lock_opened,
    input wire logic stop_open_key,
    // Climate requests from the controller
    input wire logic cool_req,
    input wire logic heat_req,
    // Fault memory kept over power cycles
    input wire logic [7:0] stored_pulse_code,
    input wire logic stored_hook_fault,
    // Drive and climate outputs
    output logic motor_enable,
    output logic brake_cmd,
    output logic coast_cmd,
    output logic cool_enable,
    output logic heat_enable,
    output logic standby_cool_enable,
    // Lid and user outputs
    output logic lid_release_allow,
    output logic lock_drive_open,
    output logic open_key_blink,
    output logic user_blocked,
    output logic user_lid_only,
    output logic program_refused,
    // Fault report
    output logic fault_active,
    output csup_pkg::csup_fault_t fault_kind,
    output logic [7:0] error_major,
    output logic [7:0] error_minor,
    output logic extra_fault,
    output logic rotor_standstill,
    // Fault memory to store
    output logic powerup_done,
    output logic [7:0] persist_pulse_code,
    output logic persist_hook_fault
);

    logic [csup_pkg::NUM_CH-1:0] chan_sig;
    logic [csup_pkg::NUM_CH-1:0] edge_v;
    logic [csup_pkg::NUM_CH-1:0] stale_v;
    logic run_prev_reg;
    logic run_start;
    logic [31:0] pu_cnt_reg;
    logic pu_done_reg;
    logic turned_reg;
    logic pu_end;
    logic overspeed;
    csup_pkg::csup_fault_t kind_reg;
    csup_pkg::csup_fault_t new_kind;
    logic extra_reg;
    logic pulse_fault;
    logic [31:0] hold_cnt_reg;
    logic hold_done_reg;
    logic [7:0] ppc_reg;
    logic phf_reg;
    logic lock_drive_reg;
    logic [31:0] blink_cnt_reg;
    logic blink_reg;
    logic refused_reg;
    logic [7:0] major_reg;
    logic [7:0] minor_reg;

    assign chan_sig = {bottom_speed_sensor, top_speed_sensor, mains_sync, imbalance_y, imbalance_x,
                       bottom_speed_sensor, top_speed_sensor};
    assign run_start = run_cmd & ~run_prev_reg;

    // One activity monitor per pulse channel; the top and bottom timeout channels restart at run start, the standstill channels do not
    for (genvar ch = 0; ch < csup_pkg::NUM_CH; ch++) begin : g_mon
        localparam int unsigned TO = (ch == csup_pkg::CH_TOP || ch == csup_pkg::CH_BOT) ? PULSE_TO :
                                     (ch == csup_pkg::CH_IMBX || ch == csup_pkg::CH_IMBY) ? IMB_TO :
                                     (ch == csup_pkg::CH_MAINS) ? MAINS_TO : STILL_TO;
        localparam bit RESTARTS = (ch == csup_pkg::CH_TOP || ch == csup_pkg::CH_BOT);
        csup_act_if act();
        csup_pulse_mon #(.TIMEOUT(TO)) u_mon (
            .clk(clk),
            .nrst(nrst),
            .sig(chan_sig[ch]),
            .restart(RESTARTS ? run_start : 1'b0),
            .act(act.mon)
        );
        assign edge_v[ch] = act.pulse_edge;
        assign stale_v[ch] = act.stale;
    end

    // Standstill: no speed edge for the standstill time
    assign rotor_standstill = stale_v[csup_pkg::CH_TOP_STILL] & stale_v[csup_pkg::CH_BOT_STILL];

    // Run start edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_prev_reg <= 1'b0;
        end else begin
            run_prev_reg <= run_cmd;
        end
    end

    // Power-up window; watches whether the rotor is turning at switch-on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pu_cnt_reg <= 32'h0;
            pu_done_reg <= 1'b0;
            turned_reg <= 1'b0;
        end else if (!pu_done_reg) begin
            pu_cnt_reg <= pu_cnt_reg + 32'd1;
            pu_done_reg <= (pu_cnt_reg >= POWERUP - 32'd1);
            if (edge_v[csup_pkg::CH_TOP] || edge_v[csup_pkg::CH_BOT]) begin
                turned_reg <= 1'b1;
            end
        end
    end

    assign pu_end = ~pu_done_reg & (pu_cnt_reg >= POWERUP - 32'd1);
    assign overspeed = program_load & (program_speed > rotor_max_speed);

    // Candidate fault this cycle, highest priority first
    always_comb begin
        new_kind = csup_pkg::CSUP_F_NONE;
        if (overspeed) begin
            new_kind = csup_pkg::CSUP_F_OVERSPEED;
        end else if (converter_init_fault) begin
            new_kind = csup_pkg::CSUP_F_CONV_INIT;
        end else if (no_rotor_fault) begin
            new_kind = csup_pkg::CSUP_F_NO_ROTOR;
        end else if (pu_end && stored_pulse_code != csup_pkg::ERR_NONE && !turned_reg) begin
            // Rotor still at switch-on: the stored pulse error comes back
            new_kind = (stored_pulse_code == csup_pkg::ERR_PULSE_BOTH) ? csup_pkg::CSUP_F_PULSE_BOTH :
                       csup_pkg::CSUP_F_PULSE_TOP;
        end else if (run_cmd && (!hook_left_closed || !hook_right_closed)) begin
            new_kind = csup_pkg::CSUP_F_LID_HOOK;
        end else if (run_cmd && stale_v[csup_pkg::CH_TOP] && stale_v[csup_pkg::CH_BOT]) begin
            new_kind = csup_pkg::CSUP_F_PULSE_BOTH;
        end else if (run_cmd && stale_v[csup_pkg::CH_TOP]) begin
            new_kind = csup_pkg::CSUP_F_PULSE_TOP;
        end else if (run_cmd && stale_v[csup_pkg::CH_BOT]) begin
            new_kind = csup_pkg::CSUP_F_PULSE_BOT;
        end else if (imbalance_detect) begin
            new_kind = csup_pkg::CSUP_F_IMBALANCE;
        end else if (single_program_checksum_fault) begin
            new_kind = csup_pkg::CSUP_F_SUM_SINGLE;
        end else if (linked_program_checksum_fault) begin
            new_kind = csup_pkg::CSUP_F_SUM_LINKED;
        end else if (stale_v[csup_pkg::CH_MAINS]) begin
            new_kind = csup_pkg::CSUP_F_MAINS;
        end else if (stale_v[csup_pkg::CH_IMBX]) begin
            new_kind = csup_pkg::CSUP_F_IMB_X;
        end else if (stale_v[csup_pkg::CH_IMBY]) begin
            new_kind = csup_pkg::CSUP_F_IMB_Y;
        end else if (imbalance_temp_defect) begin
            new_kind = csup_pkg::CSUP_F_IMB_TEMP;
        end else if (board_temp_defect) begin
            new_kind = csup_pkg::CSUP_F_TEMP_DEF;
        end else if (board_temp_over) begin
            new_kind = csup_pkg::CSUP_F_TEMP_OVER;
        end
    end

    // Fault latch: the first fault holds; only imbalance clears, on lid opening,
    // and a fresh detection in that cycle keeps it set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kind_reg <= csup_pkg::CSUP_F_NONE;
        end else if (kind_reg == csup_pkg::CSUP_F_NONE) begin
            kind_reg <= new_kind;
        end else if (kind_reg == csup_pkg::CSUP_F_IMBALANCE && !lid_closed && !imbalance_detect) begin
            kind_reg <= csup_pkg::CSUP_F_NONE;
        end
    end

    // A later different fault is flagged, not written over
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extra_reg <= 1'b0;
        end else if (kind_reg != csup_pkg::CSUP_F_NONE && new_kind != csup_pkg::CSUP_F_NONE
                     && new_kind != kind_reg) begin
            extra_reg <= 1'b1;
        end
    end

    // Error number for display, held with the latched kind
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            major_reg <= csup_pkg::ERR_NONE;
            minor_reg <= csup_pkg::ERR_NONE;
        end else begin
            minor_reg <= (kind_reg == csup_pkg::CSUP_F_LID_HOOK) ? csup_pkg::ERR_LID_MINOR : csup_pkg::ERR_NONE;
            case (kind_reg)
                csup_pkg::CSUP_F_PULSE_TOP: major_reg <= csup_pkg::ERR_PULSE_TOP;
                csup_pkg::CSUP_F_PULSE_BOTH: major_reg <= csup_pkg::ERR_PULSE_BOTH;
                csup_pkg::CSUP_F_LID_HOOK: major_reg <= csup_pkg::ERR_LID;
                csup_pkg::CSUP_F_MAINS: major_reg <= csup_pkg::ERR_MAINS;
                csup_pkg::CSUP_F_IMB_X: major_reg <= csup_pkg::ERR_IMB_X;
                csup_pkg::CSUP_F_IMB_Y: major_reg <= csup_pkg::ERR_IMB_Y;
                csup_pkg::CSUP_F_IMB_TEMP: major_reg <= csup_pkg::ERR_IMB_TEMP;
                csup_pkg::CSUP_F_PULSE_BOT: major_reg <= csup_pkg::ERR_PULSE_BOT;
                csup_pkg::CSUP_F_TEMP_DEF: major_reg <= csup_pkg::ERR_TEMP_DEF;
                csup_pkg::CSUP_F_TEMP_OVER: major_reg <= csup_pkg::ERR_TEMP_OVER;
                csup_pkg::CSUP_F_SUM_SINGLE: major_reg <= csup_pkg::ERR_SUM_SINGLE;
                csup_pkg::CSUP_F_SUM_LINKED: major_reg <= csup_pkg::ERR_SUM_LINKED;
                default: major_reg <= csup_pkg::ERR_NONE;
            endcase
        end
    end

    assign pulse_fault = (kind_reg == csup_pkg::CSUP_F_PULSE_TOP) || (kind_reg == csup_pkg::CSUP_F_PULSE_BOTH);

    // Hold timer after standstill; with sensors dead the standstill is only
    // inferred; the wait covers a rotor spinning unseen
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_cnt_reg <= 32'h0;
            hold_done_reg <= 1'b0;
        end else if (pulse_fault && rotor_standstill && !hold_done_reg) begin
            hold_cnt_reg <= hold_cnt_reg + 32'd1;
            hold_done_reg <= (hold_cnt_reg >= HOLD - 32'd1);
        end
    end

    // Pulse-error memory: reloaded at switch-on unless the rotor turned
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ppc_reg <= csup_pkg::ERR_NONE;
        end else if (pulse_fault) begin
            ppc_reg <= major_reg == csup_pkg::ERR_NONE ? ppc_reg : major_reg;
        end else if (pu_end) begin
            ppc_reg <= turned_reg ? csup_pkg::ERR_NONE : stored_pulse_code;
        end
    end

    // Hook-error memory and lock recovery at power-up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phf_reg <= 1'b0;
            lock_drive_reg <= 1'b0;
        end else begin
            if (kind_reg == csup_pkg::CSUP_F_LID_HOOK) begin
                phf_reg <= 1'b1;
            end else if (pu_end) begin
                phf_reg <= stored_hook_fault;
            end else if (pu_done_reg && lock_opened && kind_reg == csup_pkg::CSUP_F_NONE) begin
                phf_reg <= 1'b0;
            end
            if (lock_opened) begin
                lock_drive_reg <= 1'b0;
            end else if (open_key_blink_req() && stop_open_key) begin
                lock_drive_reg <= 1'b1;
            end
        end
    end

    function automatic logic open_key_blink_req();
        return pu_done_reg & phf_reg & ~lock_opened & (kind_reg == csup_pkg::CSUP_F_NONE);
    endfunction : open_key_blink_req

    // Blink generator for the open key's left indicator
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= 1'b0;
        end else if (!open_key_blink_req()) begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= 1'b0;
        end else if (blink_cnt_reg >= BLINK - 32'd1) begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'd1;
        end
    end

    // Refusal strobe for an overspeed program
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            refused_reg <= 1'b0;
        end else begin
            refused_reg <= overspeed;
        end
    end

    // Drive, climate and lid outputs follow the latched fault
    assign fault_active = (kind_reg != csup_pkg::CSUP_F_NONE);
    assign motor_enable = run_cmd & ~fault_active & ~overspeed;
    assign coast_cmd = (kind_reg == csup_pkg::CSUP_F_LID_HOOK);
    assign brake_cmd = fault_active & ~coast_cmd & ~rotor_standstill;
    assign cool_enable = cool_req & ~fault_active;
    assign heat_enable = heat_req & ~fault_active;
    assign standby_cool_enable = fault_active & rotor_standstill & lid_closed;
    assign lid_release_allow = rotor_standstill & (~pulse_fault | hold_done_reg);
    assign user_blocked = pulse_fault;
    assign user_lid_only = fault_active & ~pulse_fault;
    assign lock_drive_open = lock_drive_reg;
    assign open_key_blink = blink_reg;
    assign program_refused = refused_reg;
    assign fault_kind = kind_reg;
    assign error_major = major_reg;
    assign error_minor = minor_reg;
    assign extra_fault = extra_reg;
    assign powerup_done = pu_done_reg;
    assign persist_pulse_code = ppc_reg;
    assign persist_hook_fault = phf_reg;

endmodule : csup_supervisor

`default_nettype wire

// [tb/csup_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module csup_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Fault report
    input wire logic fault_active,
    input wire csup_pkg::csup_fault_t fault_kind,
    input wire logic [7:0] error_major,
    input wire logic [7:0] error_minor,
    // Drive, climate and lid
    input wire logic cool_enable,
    input wire logic heat_enable,
    input wire logic brake_cmd,
    input wire logic coast_cmd,
    input wire logic motor_enable,
    input wire logic user_blocked,
    input wire logic rotor_standstill,
    input wire logic lid_release_allow,
    // Program check
    input wire logic program_load,
    input wire logic [15:0] program_speed,
    input wire logic [15:0] rotor_max_speed,
    input wire logic program_refused
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Hook fault held a second cycle, numbers caught up
    sequence s_hook_held;
        fault_kind == csup_pkg::CSUP_F_LID_HOOK ##1 fault_kind == csup_pkg::CSUP_F_LID_HOOK;
    endsequence
    a_climate_off: assert property (fault_active |-> !cool_enable && !heat_enable) else $error("climate on");
    a_lid_waits_still: assert property (fault_active && !rotor_standstill |-> !lid_release_allow)
        else $error("lid freed while turning");
    a_pulse_blocks: assert property (fault_kind inside {csup_pkg::CSUP_F_PULSE_TOP, csup_pkg::CSUP_F_PULSE_BOTH}
        |-> user_blocked && !motor_enable) else $error("pulse not blocking");
    a_imb_braked: assert property (fault_kind == csup_pkg::CSUP_F_IMBALANCE && !rotor_standstill
        |-> brake_cmd && !coast_cmd) else $error("imbalance not braked");
    a_hook_coasts: assert property (fault_kind == csup_pkg::CSUP_F_LID_HOOK |-> coast_cmd && !brake_cmd)
        else $error("hook fault braked");
    a_hook_number: assert property (s_hook_held |-> error_major == 8'h04 && error_minor == 8'h01)
        else $error("hook number wrong");
    a_overspeed_refused: assert property (program_load && program_speed > rotor_max_speed && !fault_active
        |=> program_refused && fault_kind == csup_pkg::CSUP_F_OVERSPEED) else $error("overspeed not refused");
    a_refuse_cause: assert property (!program_load |=> !program_refused) else $error("refused without load");
    a_latch_holds: assert property (fault_active && fault_kind != csup_pkg::CSUP_F_IMBALANCE
        |=> $stable(fault_kind)) else $error("latched fault changed");
endmodule : csup_asserts
`default_nettype wire

// [tb/csup_sensor_model.sv]
`timescale 1ns/1ns
`default_nettype none
module csup_sensor_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Enables and waves: top, bottom, imbalance x, imbalance y, mains
    input wire logic [4:0] en,
    output logic [4:0] sig
);
    logic [1:0] div_reg;
    // A stopped channel holds its level, like a dead sensor
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= 2'h0;
            sig <= 5'h00;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h3) begin
                sig <= sig ^ en;
            end
        end
    end
endmodule : csup_sensor_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0, nrst = 1'b0, lid_closed, hook_left_closed, hook_right_closed, lock_opened, stop_open_key;
    logic cool_req, heat_req, run_cmd, program_load, imbalance_detect, stored_hook_fault, imbalance_temp_defect;
    logic board_temp_defect, board_temp_over, converter_init_fault, no_rotor_fault, single_program_checksum_fault;
    logic linked_program_checksum_fault, top_speed_sensor, bottom_speed_sensor, imbalance_x, imbalance_y, mains_sync;
    logic motor_enable, brake_cmd, coast_cmd, cool_enable, heat_enable, standby_cool_enable, lid_release_allow;
    logic lock_drive_open, open_key_blink, user_blocked, user_lid_only, program_refused, fault_active, extra_fault;
    logic rotor_standstill, powerup_done, persist_hook_fault, b;
    logic [15:0] program_speed, rotor_max_speed;
    logic [7:0] stored_pulse_code, error_major, error_minor, persist_pulse_code;
    logic [4:0] en;
    csup_pkg::csup_fault_t fault_kind;
    int miscompares = 0, tests_run = 0, cycles = 0;
    csup_sensor_model model_u (.clk(clk), .nrst(nrst), .en(en),
        .sig({mains_sync, imbalance_y, imbalance_x, bottom_speed_sensor, top_speed_sensor}));
    // Short counts keep the hold and timeouts brief
    csup_supervisor #(.PULSE_TO(50), .STILL_TO(80), .IMB_TO(40), .MAINS_TO(60), .POWERUP(30), .HOLD(200),
        .BLINK(8)) dut_u (.*);
    always #50 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // Power cycle; most faults clear no other way
    task automatic power_up(input logic [7:0] code, input logic hook, input logic [4:0] e);
        nrst = 1'b0;
        {lid_closed, hook_left_closed, hook_right_closed, cool_req, heat_req} = 5'h1f;
        {stop_open_key, run_cmd, program_load, imbalance_detect} = 4'h0;
        {imbalance_temp_defect, board_temp_defect, board_temp_over, single_program_checksum_fault,
            linked_program_checksum_fault, converter_init_fault, no_rotor_fault} = 7'h00;
        {program_speed, rotor_max_speed, en} = {16'h0100, 16'h0100, e};
        {stored_pulse_code, stored_hook_fault, lock_opened} = {code, hook, !hook};
        cyc(6);
        nrst = 1'b1;
        cyc(36);
    endtask : power_up
    task automatic wait_fault();
        for (int k = 0; k < 300 && fault_active !== 1'b1; k++) cyc(1);
        cyc(2);
    endtask : wait_fault
    task automatic t_table();
        logic [7:0] exp [12] = '{csup_pkg::ERR_IMB_TEMP, csup_pkg::ERR_TEMP_DEF, csup_pkg::ERR_TEMP_OVER,
            csup_pkg::ERR_SUM_SINGLE, csup_pkg::ERR_SUM_LINKED, 8'h00, 8'h00, csup_pkg::ERR_PULSE_TOP,
            csup_pkg::ERR_PULSE_BOT, csup_pkg::ERR_IMB_X, csup_pkg::ERR_IMB_Y, csup_pkg::ERR_MAINS};
        for (int i = 0; i < 12; i++) begin
            power_up(8'h00, 1'b0, 5'h1f);
            run_cmd = 1'b1;
            if (i < 7) {imbalance_temp_defect, board_temp_defect, board_temp_over, single_program_checksum_fault,
                linked_program_checksum_fault, converter_init_fault, no_rotor_fault} = 7'h40 >> i;
            else en = 5'h1f ^ 5'(1 << (i - 7));
            wait_fault();
            chk("error_major", error_major, exp[i]);
            chk("fault_active", fault_active, 1'b1);
            chk("brake_cmd", brake_cmd, 1'b1);
            chk("cool_enable", cool_enable, 1'b0);
        end
    endtask : t_table
    task automatic t_hold();
        power_up(8'h00, 1'b0, 5'h1f);
        run_cmd = 1'b1;
        en = 5'h1c;
        wait_fault();
        chk("kind_both", fault_kind, csup_pkg::CSUP_F_PULSE_BOTH);
        chk("user_blocked", user_blocked, 1'b1);
        for (int k = 0; k < 300 && rotor_standstill !== 1'b1; k++) cyc(1);
        cyc(150);
        chk("lid_in_hold", lid_release_allow, 1'b0);
        chk("standby", standby_cool_enable, 1'b1);
        cyc(70);
        chk("lid_after_hold", lid_release_allow, 1'b1);
    endtask : t_hold
    task automatic t_hook();
        power_up(8'h00, 1'b0, 5'h1f);
        run_cmd = 1'b1;
        hook_left_closed = 1'b0;
        cyc(1);
        chk("kind_hook", fault_kind, csup_pkg::CSUP_F_LID_HOOK);
        chk("coast_cmd", coast_cmd, 1'b1);
        chk("lid_only", user_lid_only, 1'b1);
        cyc(1);
        chk("minor_hook", error_minor, csup_pkg::ERR_LID_MINOR);
        chk("persist_hook", persist_hook_fault, 1'b1);
        {hook_left_closed, imbalance_detect} = 2'h3;
        cyc(2);
        chk("extra_fault", extra_fault, 1'b1);
        chk("kind_kept", fault_kind, csup_pkg::CSUP_F_LID_HOOK);
    endtask : t_hook
    task automatic t_imb_over();
        power_up(8'h00, 1'b0, 5'h1f);
        program_load = 1'b1;
        cyc(1);
        program_load = 1'b0;
        chk("refused_equal", program_refused, 1'b0);
        {program_speed, program_load} = {16'h0101, 1'b1};
        cyc(1);
        program_load = 1'b0;
        chk("refused_above", program_refused, 1'b1);
        power_up(8'h00, 1'b0, 5'h1f);
        {run_cmd, imbalance_detect} = 2'h3;
        wait_fault();
        chk("kind_imb", fault_kind, csup_pkg::CSUP_F_IMBALANCE);
        {lid_closed, imbalance_detect} = 2'h0;
        cyc(2);
        chk("imb_cleared", fault_active, 1'b0);
    endtask : t_imb_over
    task automatic t_power();
        power_up(8'h02, 1'b0, 5'h1c);
        chk("stored_kept", fault_kind, csup_pkg::CSUP_F_PULSE_BOTH);
        power_up(8'h01, 1'b0, 5'h1f);
        chk("stored_cleared", fault_active, 1'b0);
        chk("pu_done", powerup_done, 1'b1);
        power_up(8'h00, 1'b1, 5'h1f);
        b = open_key_blink;
        cyc(8);
        chk("blink", open_key_blink, !b);
        stop_open_key = 1'b1;
        cyc(2);
        chk("lock_drive", lock_drive_open, 1'b1);
        {stop_open_key, lock_opened} = 2'h1;
        cyc(2);
        chk("lock_stop", lock_drive_open, 1'b0);
    endtask : t_power
    // Ends a hang, far above the run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        t_table();
        $display("table test done");
        t_hold();
        $display("hold test done");
        t_hook();
        $display("hook test done");
        t_imb_over();
        $display("overspeed test done");
        t_power();
        $display("power-up test done");
        print_verdict();
    end
endmodule : tb
bind csup_supervisor csup_asserts chk_u (.*);
`default_nettype wire
